// *** drm_cfg.svh ***
/*
 * constants for the page-mode dram controller: times in ns (power-up in us, refresh in ms) as printed for
 * the fastest speed grade, and the clock-cycle counts derived from them.
 * assumes a 200 MHz system clock; included by bare name.
 */
// Overview of operation
// R01: the dram enables or disables its data output by column strobe alone.
// R02: after a read the dram holds output data while column strobe stays low.
// R03: column strobe high returns the dram data output to high impedance; the dram model drives the inverse of the held bit instead.
// R04: with row strobe low, column strobe toggles give successive page accesses.
// R05: column strobe before row strobe refreshes the dram internal counter row.
// R06: all 512 refresh rows are refreshed within every 8 ms interval.
// R07: the array holds 1,048,576 one-bit words, row then column addressed.
// R08: successive random cycles are spaced by at least 160 ns.
// R09: row strobe stays low no longer than 100000 ns in page mode.
// R10: column strobe stays high at least 10 ns between page cycles.
// R11: for refresh, column strobe falls at least 10 ns before row strobe.
// R12: in refresh, column strobe stays low 15 ns after row strobe falls.
// R13: column strobe falls 25 to 60 ns after row strobe falls.
// R14: read data is valid by 80 ns after row strobe falls.
// R15: read data is valid within 45 ns of a stable column address.
// R16: read data is valid within 20 ns of column strobe falling.
// R17: page read data is valid within 45 ns of column strobe rising.
// R18: write strobe is low no later than column strobe falls.
// R19: write strobe is low at least 25 ns before row strobe rises.
// R20: after power-up wait 100 us, then eight row strobe cycles.
// R21: early write meets write-strobe setup and hold around column strobe fall.
// R22: beyond the row-to-column limit, access follows column strobe access time.
// R23: a read keeps write strobe high until after column or row strobe rises.
// R24: word address splits into 10-bit row half and 10-bit column half.
`ifndef DRM_CFG_SVH
`define DRM_CFG_SVH

`define DRM_CLK_NS 5
`define DRM_CEIL(ns) (((ns) + `DRM_CLK_NS - 1) / `DRM_CLK_NS)
`define DRM_FLOOR(ns) ((ns) / `DRM_CLK_NS)

`define DRM_ADDR_W 20
`define DRM_HALF_W 10
`define DRM_CNT_W 16
`define DRM_WORDS 1048576
`define DRM_REF_ROWS 512
`define DRM_INIT_CYCLES 8

`define DRM_RANDOM_CYCLE_MIN_NS 160
`define DRM_RAS_WIDTH_MIN_NS 80
`define DRM_RAS_PRECHARGE_NS 70
`define DRM_PAGE_ROW_OPEN_MAX_NS 100000
`define DRM_PAGE_COL_PRECHARGE_NS 10
`define DRM_CBR_COL_SETUP_NS 10
`define DRM_CBR_COL_HOLD_NS 15
`define DRM_ROW_TO_COL_DELAY_NS 25
`define DRM_ROW_ACCESS_TIME_NS 80
`define DRM_COL_ADDR_ACCESS_TIME_NS 45
`define DRM_COL_STROBE_ACCESS_TIME_NS 20
`define DRM_WRITE_TO_ROW_LEAD_NS 25
`define DRM_POWERUP_WAIT_US 100
`define DRM_REFRESH_INTERVAL_MS 8

`define DRM_RC_CYC `DRM_CEIL(`DRM_RANDOM_CYCLE_MIN_NS)
`define DRM_RAS_CYC `DRM_CEIL(`DRM_RAS_WIDTH_MIN_NS)
`define DRM_RP_MIN_CYC `DRM_CEIL(`DRM_RAS_PRECHARGE_NS)
`define DRM_RP_CYC (`DRM_RC_CYC - `DRM_RAS_CYC)
`define DRM_CP_CYC `DRM_CEIL(`DRM_PAGE_COL_PRECHARGE_NS)
`define DRM_CSR_CYC `DRM_CEIL(`DRM_CBR_COL_SETUP_NS)
`define DRM_CHR_CYC `DRM_CEIL(`DRM_CBR_COL_HOLD_NS)
`define DRM_RCD_CYC `DRM_CEIL(`DRM_ROW_TO_COL_DELAY_NS)
`define DRM_RAC_CYC `DRM_CEIL(`DRM_ROW_ACCESS_TIME_NS)
`define DRM_AA_CYC `DRM_CEIL(`DRM_COL_ADDR_ACCESS_TIME_NS)
`define DRM_CAC_CYC `DRM_CEIL(`DRM_COL_STROBE_ACCESS_TIME_NS)
`define DRM_RWL_CYC `DRM_CEIL(`DRM_WRITE_TO_ROW_LEAD_NS)
// column strobe low time: row access dominates column access and write lead
`define DRM_CAS_LOW_CYC (`DRM_RAC_CYC - `DRM_RCD_CYC + 1)
`define DRM_RASP_CYC `DRM_FLOOR(`DRM_PAGE_ROW_OPEN_MAX_NS)
`define DRM_PWR_CYC `DRM_CEIL(`DRM_POWERUP_WAIT_US * 1000)
`define DRM_REF_INT_CYC `DRM_FLOOR(`DRM_REFRESH_INTERVAL_MS * 1000000)
// margin kept before the row-open limit so a final column cycle still fits
`define DRM_PAGE_GUARD_CYC (`DRM_CAS_LOW_CYC + `DRM_CP_CYC + 4)

`endif

// *** drm_pkg.sv ***
/*
 * types for the page-mode dram controller.
 * assumes drm_cfg.svh for all numeric constants.
 */
package drm_pkg;

   // controller states, gray coded along idle-row-column-page-precharge
   typedef enum logic [3:0] {
      DRM_ST_PWR  = 4'h5,
      DRM_ST_IDLE = 4'h0,
      DRM_ST_RCD  = 4'h1,
      DRM_ST_CAS  = 4'h3,
      DRM_ST_PAGE = 4'h2,
      DRM_ST_RP   = 4'h6,
      DRM_ST_CBR  = 4'h7
   } drm_state_t;

endpackage

// *** drm_ref_if.sv ***
/*
 * refresh request handshake between scheduler and controller.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface drm_ref_if;
   logic due; // a refresh row is owed
   logic ack; // one refresh cycle started
   modport sched (output due, input ack);
   modport ctrl (input due, output ack);
endinterface

`default_nettype wire

// *** drm_refresh_sched.sv ***
/*
 * refresh scheduler: raises a sticky request once per row slot so that all
 * rows are covered within the refresh interval.
 * assumes the controller acknowledges with a one-cycle pulse.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drm_cfg.svh"

module drm_refresh_sched #(
   parameter int P_REF_INT_CYC = `DRM_REF_INT_CYC,
   parameter int P_ROWS = `DRM_REF_ROWS
) (
   input wire logic i_sys_clk,  // system clock
   input wire logic i_reset,    // synchronous reset, active high
   drm_ref_if.sched ref_port    // request towards controller
);

   localparam int SLOT_CYC = P_REF_INT_CYC / P_ROWS;

   logic [`DRM_CNT_W-1:0] slot_cnt;
   logic [`DRM_CNT_W-1:0] next_slot_cnt;
   logic due;
   logic next_due;
   logic tick;

   // ----------------------------------------
   // slot timer and sticky request
   // ----------------------------------------
   // a new slot tick wins over an acknowledge in the same cycle
   always_comb begin
      tick = (slot_cnt == `DRM_CNT_W'(SLOT_CYC - 1));
      next_slot_cnt = tick ? '0 : slot_cnt + `DRM_CNT_W'(1); // R06
      next_due = tick | (due & ~ref_port.ack);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         slot_cnt <= '0;
         due <= 1'b0;
      end else begin
         slot_cnt <= next_slot_cnt;
         due <= next_due;
      end
   end

   assign ref_port.due = due;

endmodule

`default_nettype wire

// *** drm_ctrl.sv ***
/*
 * page-mode dram controller: takes word reads and writes on a simple
 * request port and drives row strobe, column strobe, write strobe, the
 * shared address pins and data-in of a 1M x 1 dram; samples its data-out.
 * assumes the dram pins are driven straight from this module's outputs.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drm_cfg.svh"

module drm_ctrl #(
   parameter int P_PWR_CYC = `DRM_PWR_CYC,
   parameter int P_RASP_CYC = `DRM_RASP_CYC,
   parameter int P_REF_INT_CYC = `DRM_REF_INT_CYC
) (
   input wire logic i_sys_clk,                  // system clock, 200 MHz
   input wire logic i_reset,                    // synchronous reset
   input wire logic i_req,                      // access request
   input wire logic i_we,                       // 1 write, 0 read
   input wire logic [`DRM_ADDR_W-1:0] i_addr,   // word address
   input wire logic i_wdata,                    // write bit
   output logic o_ready,                        // request taken when high
   output logic o_rvalid,                       // read data pulse
   output logic o_rdata,                        // read bit
   output logic o_init_done,                    // power-up sequence over
   output logic o_ras_n,                        // row strobe
   output logic o_cas_n,                        // column strobe
   output logic o_we_n,                         // write strobe
   output logic [`DRM_HALF_W-1:0] o_addr,       // multiplexed address
   output logic o_din,                          // dram data in
   input wire logic i_dout                      // dram data out
);

   localparam int GUARD = P_RASP_CYC - `DRM_PAGE_GUARD_CYC;

   drm_ref_if ref_bus ();

   drm_refresh_sched #(
      .P_REF_INT_CYC(P_REF_INT_CYC),
      .P_ROWS(`DRM_REF_ROWS)
   ) u_sched (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .ref_port(ref_bus)
   );

   drm_pkg::drm_state_t state, next_state;
   logic [`DRM_CNT_W-1:0] cnt, next_cnt;
   logic [`DRM_CNT_W-1:0] ras_cnt, next_ras_cnt;
   logic [3:0] init_cnt, next_init_cnt;
   logic [`DRM_ADDR_W-1:0] lat_addr, next_lat_addr;
   logic lat_we, next_lat_we;
   logic lat_wdata, next_lat_wdata;
   logic pend, next_pend;
   logic next_ready, next_rvalid, next_rdata, next_init_done;
   logic next_ras_n, next_cas_n, next_we_n, next_din;
   logic [`DRM_HALF_W-1:0] next_addr;
   logic take, same_row, near_limit, ack;

   // ----------------------------------------
   // sequencer next values
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt + `DRM_CNT_W'(1);
      next_init_cnt = init_cnt;
      next_lat_addr = lat_addr;
      next_lat_we = lat_we;
      next_lat_wdata = lat_wdata;
      next_pend = pend;
      next_rvalid = 1'b0;
      next_rdata = o_rdata;
      next_ras_n = o_ras_n;
      next_cas_n = o_cas_n;
      next_we_n = o_we_n;
      next_addr = o_addr;
      next_din = o_din;
      ack = 1'b0;
      take = o_ready & i_req;
      same_row = (i_addr[`DRM_ADDR_W-1:`DRM_HALF_W] == lat_addr[`DRM_ADDR_W-1:`DRM_HALF_W]);
      near_limit = (ras_cnt >= `DRM_CNT_W'(GUARD));
      if (take) begin
         next_lat_addr = i_addr;
         next_lat_we = i_we;
         next_lat_wdata = i_wdata;
      end
      case (state)
         // power-up pause with row strobe inactive
         drm_pkg::DRM_ST_PWR: begin
            if (cnt == `DRM_CNT_W'(P_PWR_CYC - 1)) begin // R20
               next_state = drm_pkg::DRM_ST_IDLE;
               next_cnt = '0;
            end
         end
         drm_pkg::DRM_ST_IDLE: begin
            next_cnt = '0;
            if (take) begin
               // row half first on the shared pins
               next_addr = i_addr[`DRM_ADDR_W-1:`DRM_HALF_W]; // R24
               next_ras_n = 1'b0;
               next_state = drm_pkg::DRM_ST_RCD;
            end else if (ref_bus.due || !o_init_done) begin
               // column strobe leads row strobe: internal refresh row
               next_cas_n = 1'b0; // R05
               next_state = drm_pkg::DRM_ST_CBR;
               ack = ref_bus.due;
            end
         end
         drm_pkg::DRM_ST_RCD: begin
            if (cnt == `DRM_CNT_W'(`DRM_RCD_CYC - 1)) begin // R13
               next_addr = lat_addr[`DRM_HALF_W-1:0]; // R24
               next_cas_n = 1'b0;
               next_we_n = ~lat_we; // R18 R21 R23
               next_din = lat_wdata;
               next_state = drm_pkg::DRM_ST_CAS;
               next_cnt = '0;
            end
         end
         drm_pkg::DRM_ST_CAS: begin
            // held long enough for row, column and address access times
            if (cnt == `DRM_CNT_W'(`DRM_CAS_LOW_CYC - 1)) begin // R14 R15 R16 R17 R19 R22
               if (lat_we == 1'b0) begin
                  next_rdata = i_dout; // R02
                  next_rvalid = 1'b1;
               end
               next_cas_n = 1'b1; // R03
               next_we_n = 1'b1;
               next_state = drm_pkg::DRM_ST_PAGE;
               next_cnt = '0;
            end
         end
         // row open, column strobe in precharge
         drm_pkg::DRM_ST_PAGE: begin
            if (take && same_row) begin
               next_addr = i_addr[`DRM_HALF_W-1:0]; // R04
               next_cas_n = 1'b0;
               next_we_n = ~i_we;
               next_din = i_wdata;
               next_state = drm_pkg::DRM_ST_CAS;
               next_cnt = '0;
            end else if (take || ref_bus.due || near_limit) begin
               next_pend = take;
               next_ras_n = 1'b1; // R09
               next_state = drm_pkg::DRM_ST_RP;
               next_cnt = '0;
            end
         end
         drm_pkg::DRM_ST_RP: begin
            if (cnt == `DRM_CNT_W'(`DRM_RP_CYC - 1)) begin // R08
               next_cnt = '0;
               if (pend) begin
                  next_pend = 1'b0;
                  next_addr = lat_addr[`DRM_ADDR_W-1:`DRM_HALF_W];
                  next_ras_n = 1'b0;
                  next_state = drm_pkg::DRM_ST_RCD;
               end else begin
                  next_state = drm_pkg::DRM_ST_IDLE;
               end
            end
         end
         drm_pkg::DRM_ST_CBR: begin
            if (cnt == `DRM_CNT_W'(`DRM_CSR_CYC - 1)) begin
               next_ras_n = 1'b0; // R11
            end
            if (cnt == `DRM_CNT_W'(`DRM_CSR_CYC + `DRM_CHR_CYC - 1)) begin
               next_cas_n = 1'b1; // R12
            end
            if (cnt == `DRM_CNT_W'(`DRM_CSR_CYC + `DRM_RAS_CYC - 1)) begin
               next_ras_n = 1'b1;
               next_state = drm_pkg::DRM_ST_RP;
               next_cnt = '0;
               if (!o_init_done) begin
                  next_init_cnt = init_cnt + 4'h1; // R20
               end
            end
         end
         default: begin
            next_state = drm_pkg::DRM_ST_IDLE;
            next_cnt = '0;
            next_ras_n = 1'b1;
            next_cas_n = 1'b1;
            next_we_n = 1'b1;
         end
      endcase
      next_ras_cnt = next_ras_n ? '0 : ras_cnt + `DRM_CNT_W'(1);
      next_init_done = (next_init_cnt == 4'(`DRM_INIT_CYCLES));
      // ready only where the next request can start without a wait;
      // an owed refresh closes idle to requests so a busy stream cannot starve it
      next_ready = (next_state == drm_pkg::DRM_ST_IDLE && o_init_done && !ref_bus.due) || // R06
         (next_state == drm_pkg::DRM_ST_PAGE && !ref_bus.due && // R10
          next_cnt >= `DRM_CNT_W'(`DRM_CP_CYC - 1) && !near_limit);
   end

   assign ref_bus.ack = ack;

   // ----------------------------------------
   // sequencer registers
   // ----------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state <= drm_pkg::DRM_ST_PWR;
         cnt <= '0;
         ras_cnt <= '0;
         init_cnt <= 4'h0;
         lat_addr <= '0;
         lat_we <= 1'b0;
         lat_wdata <= 1'b0;
         pend <= 1'b0;
         o_ready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 1'b0;
         o_init_done <= 1'b0;
         o_ras_n <= 1'b1;
         o_cas_n <= 1'b1;
         o_we_n <= 1'b1;
         o_addr <= '0;
         o_din <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         ras_cnt <= next_ras_cnt;
         init_cnt <= next_init_cnt;
         lat_addr <= next_lat_addr;
         lat_we <= next_lat_we;
         lat_wdata <= next_lat_wdata;
         pend <= next_pend;
         o_ready <= next_ready;
         o_rvalid <= next_rvalid;
         o_rdata <= next_rdata;
         o_init_done <= next_init_done;
         o_ras_n <= next_ras_n;
         o_cas_n <= next_cas_n;
         o_we_n <= next_we_n;
         o_addr <= next_addr;
         o_din <= next_din;
      end
   end

endmodule

`default_nettype wire

// *** drm_ctrl_asserts.sv ***
/*
 * checker on the dram pins and request port of the page-mode controller.
 * assumes it is bound onto drm_ctrl, one clock, synchronous reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drm_cfg.svh"

module drm_ctrl_asserts #(
   parameter int P_PWR_CYC = 20,
   parameter int P_RASP_CYC = 60,
   parameter int P_REF_INT_CYC = 51200
) (
   input wire logic i_sys_clk, // clock
   input wire logic i_reset, // reset
   input wire logic i_req, // request
   input wire logic [`DRM_ADDR_W-1:0] i_addr, // word address
   input wire logic i_wdata, // write bit
   input wire logic o_ready, // ready
   input wire logic o_rvalid, // read pulse
   input wire logic o_init_done, // init over
   input wire logic o_ras_n, // row strobe
   input wire logic o_cas_n, // column strobe
   input wire logic o_we_n, // write strobe
   input wire logic [`DRM_HALF_W-1:0] o_addr, // dram address
   input wire logic o_din // dram data in
);
   localparam int RC_CYC = `DRM_RC_CYC; // random cycle floor in clocks
   localparam int SLOT_CYC = P_REF_INT_CYC / `DRM_REF_ROWS + 100; // row slot plus a row close
   int gap, low_cnt, ref_cnt, up_cnt, n_fall;
   logic ras_q;
   logic [`DRM_ADDR_W-1:0] req_q;
   logic din_q;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // counts since last row fall, refresh and reset; last taken request
   always_ff @(posedge i_sys_clk) begin
      ras_q <= o_ras_n;
      low_cnt <= o_ras_n ? 0 : low_cnt + 1;
      if (o_ready && i_req) begin
         req_q <= i_addr;
         din_q <= i_wdata;
      end
      if (i_reset) begin
         gap <= 1000;
         ref_cnt <= 0;
         up_cnt <= 0;
         n_fall <= 0;
      end else begin
         gap <= (ras_q && !o_ras_n) ? 1 : (gap < 1000 ? gap + 1 : gap);
         ref_cnt <= (ras_q && !o_ras_n && !o_cas_n) ? 0 : ref_cnt + 1;
         up_cnt <= (up_cnt < P_PWR_CYC) ? up_cnt + 1 : up_cnt;
         n_fall <= (ras_q && !o_ras_n && n_fall < 15) ? n_fall + 1 : n_fall;
      end
   end
   // ----------------------------------------
   // strobe sequencing
   // ----------------------------------------
   sequence s_cbr; $fell(o_ras_n) && !o_cas_n; endsequence
   sequence s_act; $fell(o_ras_n) && o_cas_n; endsequence
   property p_row_gap; $fell(o_ras_n) |-> gap >= RC_CYC; endproperty
   a_row_gap: assert property (p_row_gap) else $error("row cycles too close");
   property p_row_open; !o_ras_n |-> low_cnt < P_RASP_CYC; endproperty
   a_row_open: assert property (p_row_open) else $error("row open too long");
   property p_page_pre; $rose(o_cas_n) |-> o_cas_n [*2]; endproperty
   a_page_pre: assert property (p_page_pre) else $error("column precharge short");
   property p_cbr_setup; s_cbr |-> !$past(o_cas_n, 2); endproperty
   a_cbr_setup: assert property (p_cbr_setup) else $error("refresh setup short");
   property p_cbr_hold; s_cbr |-> !o_cas_n [*3]; endproperty
   a_cbr_hold: assert property (p_cbr_hold) else $error("refresh hold short");
   property p_row_col; s_act |-> o_cas_n [*5] ##[1:8] !o_cas_n; endproperty
   a_row_col: assert property (p_row_col) else $error("row to column delay");
   property p_row_addr; s_act |-> o_addr == req_q[19:10]; endproperty
   a_row_addr: assert property (p_row_addr) else $error("row half wrong");
   property p_col_addr; $fell(o_cas_n) && !o_ras_n |-> o_addr == req_q[9:0]; endproperty
   a_col_addr: assert property (p_col_addr) else $error("column half wrong");
   property p_wr_start; $fell(o_we_n) |-> $fell(o_cas_n) && o_din == din_q ##0 !o_ras_n [*5];
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("write strobe timing");
   property p_we_hold; !o_cas_n && !$past(o_cas_n) |-> $stable(o_we_n); endproperty
   a_we_hold: assert property (p_we_hold) else $error("write strobe moved");
   property p_init; $rose(o_init_done) |-> n_fall >= 8 && up_cnt == P_PWR_CYC; endproperty
   a_init: assert property (p_init) else $error("init done early");
   property p_pwr; up_cnt < P_PWR_CYC |-> o_ras_n; endproperty
   a_pwr: assert property (p_pwr) else $error("row strobe in power-up wait");
   property p_read_ans; $fell(o_cas_n) && o_we_n && !o_ras_n |-> ##12 o_rvalid; endproperty
   a_read_ans: assert property (p_read_ans) else $error("read pulse late");
   property p_ref_slot; o_init_done |-> ref_cnt <= SLOT_CYC; endproperty
   a_ref_slot: assert property (p_ref_slot) else $error("refresh overdue");
endmodule

bind drm_ctrl drm_ctrl_asserts #(.P_PWR_CYC(P_PWR_CYC), .P_RASP_CYC(P_RASP_CYC),
   .P_REF_INT_CYC(P_REF_INT_CYC)) u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
   .i_req(i_req), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
   .o_rvalid(o_rvalid), .o_init_done(o_init_done), .o_ras_n(o_ras_n),
   .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_din(o_din));

`default_nettype wire

// *** drm_dram_model.sv ***
/*
 * behavioural 1M x 1 dram with fast-page access and cbr refresh.
 * assumes strobes and address change together on controller clock edges.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drm_cfg.svh"

module drm_dram_model (
   input wire logic i_ras_n, // row strobe
   input wire logic i_cas_n, // column strobe
   input wire logic i_we_n, // write strobe
   input wire logic [`DRM_HALF_W-1:0] i_addr, // shared address
   input wire logic i_din, // data in
   output logic o_dout // data out
);
   logic mem [0:`DRM_WORDS-1];
   logic [`DRM_HALF_W-1:0] row = 10'h000;
   logic [`DRM_HALF_W-1:0] col = 10'h000;
   logic [8:0] ref_row = 9'h000;
   initial o_dout = 1'b0;
   // row half or internal refresh on row strobe fall, once inputs settle
   always @(negedge i_ras_n) begin
      #1;
      if (i_cas_n) begin
         row = i_addr;
      end else begin
         ref_row = ref_row + 9'h001;
      end
   end
   // early write, or read bit valid 19 ns after the column strobe falls
   always @(negedge i_cas_n) begin
      #1;
      col = i_addr;
      if (!i_ras_n && !i_we_n) begin
         mem[{row, col}] = i_din;
      end else if (!i_ras_n) begin
         o_dout = ~mem[{row, col}];
         #18 o_dout = mem[{row, col}];
      end
   end
   // output released by column strobe alone: show the inverse bit
   always @(posedge i_cas_n) o_dout = ~o_dout;
endmodule

`default_nettype wire

// *** test_drm_ctrl.sv ***
/*
 * self-checking bench for the page-mode dram controller.
 * assumes drm_dram_model on the pins and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drm_cfg.svh"

module test_drm_ctrl;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_req = 1'b0;
   logic i_we = 1'b0;
   logic [`DRM_ADDR_W-1:0] i_addr = 20'h00000;
   logic i_wdata = 1'b0;
   logic o_ready, o_rvalid, o_rdata, o_init_done, o_ras_n, o_cas_n, o_we_n, o_din, i_dout;
   logic [`DRM_HALF_W-1:0] o_addr;
   logic [`DRM_ADDR_W-1:0] tbl [6] = '{20'h00000, 20'hfffff, 20'h80200, 20'h7fdff,
      20'h001ff, 20'h3fe01};
   int fail_count = 0;
   int n_compared = 0;
   int n_ref = 0;
   // 200 MHz clock
   always #2.5 i_sys_clk = ~i_sys_clk;
   // refresh cycles seen on the pins
   always @(negedge o_ras_n) if (o_cas_n === 1'b0) n_ref++;
   drm_ctrl #(.P_PWR_CYC(20), .P_RASP_CYC(60), .P_REF_INT_CYC(51200)) i_dut (
      .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(i_req), .i_we(i_we),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
      .o_rdata(o_rdata), .o_init_done(o_init_done), .o_ras_n(o_ras_n),
      .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_din(o_din), .i_dout(i_dout));
   drm_dram_model i_dram (.i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n),
      .i_addr(o_addr), .i_din(o_din), .o_dout(i_dout));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one request held until taken; a read waits for its pulse
   task automatic access(input logic we, input logic [19:0] a, input logic wd, output logic rd);
      int n;
      @(negedge i_sys_clk);
      i_req = 1'b1;
      i_we = we;
      i_addr = a;
      i_wdata = wd;
      for (n = 0; o_ready !== 1'b1 && n < 2000; n++) @(negedge i_sys_clk);
      if (n == 2000) check(20'(o_ready), 20'h00001);
      @(negedge i_sys_clk);
      i_req = 1'b0;
      for (n = 0; !we && o_rvalid !== 1'b1 && n < 40; n++) @(negedge i_sys_clk);
      rd = (o_rvalid === 1'b1) ? o_rdata : 1'bx;
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_init();
      int n;
      for (n = 0; o_init_done !== 1'b1 && n < 5000; n++) @(negedge i_sys_clk);
      check(20'(n_ref), 20'h00008);
   endtask
   // page writes at column edges, read back in reverse order
   task automatic t_page();
      logic [9:0] cols [4] = '{10'h000, 10'h001, 10'h155, 10'h3ff};
      logic rd;
      for (int i = 0; i < 4; i++) access(1'b1, {10'h2aa, cols[i]}, i[0] ^ i[1], rd);
      for (int i = 3; i >= 0; i--) begin
         access(1'b0, {10'h2aa, cols[i]}, 1'b0, rd);
         check({19'h0, rd}, {19'h0, i[0] ^ i[1]});
      end
   endtask
   // row misses across boundary addresses
   task automatic t_rows();
      logic rd;
      for (int i = 0; i < 6; i++) access(1'b1, tbl[i], ^tbl[i], rd);
      for (int i = 0; i < 6; i++) begin
         access(1'b0, tbl[i], 1'b0, rd);
         check({19'h0, rd}, {19'h0, ^tbl[i]});
      end
   endtask
   // idle spell: refreshes keep coming, data survives
   task automatic t_refresh();
      int n0;
      logic rd;
      n0 = n_ref;
      repeat (600) @(negedge i_sys_clk);
      check(20'(n_ref - n0 >= 5 && n_ref - n0 <= 7), 20'h00001);
      access(1'b0, tbl[2], 1'b0, rd);
      check({19'h0, rd}, {19'h0, ^tbl[2]});
   endtask
   // reset in mid-run restarts the power-up sequence
   task automatic t_reset();
      @(negedge i_sys_clk);
      i_reset = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      check({15'h0, o_ras_n, o_cas_n, o_we_n, o_init_done, o_ready}, 20'h0001c);
      n_ref = 0;
      i_reset = 1'b0;
   endtask
   // main sequence
   initial begin
      repeat (4) @(negedge i_sys_clk);
      i_reset = 1'b0;
      t_init();
      t_page();
      t_rows();
      t_refresh();
      t_reset();
      t_init();
      t_rows();
      finish_test();
   end
   // watchdog
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule

`default_nettype wire
